// ===== hw/riot_pkg.sv
// Package: address decode, field positions, prescale and timing constants
package riot_pkg;
    localparam int        DATA_W       = 8;
    localparam int        ADDR_W       = 7;
    localparam int        RAM_DEPTH    = 128;
    // Address bit positions
    localparam int        A_BIT0       = 0;
    localparam int        A_BIT1       = 1;
    localparam int        A_BIT2       = 2;
    localparam int        A_BIT3       = 3;
    localparam int        A_BIT4       = 4;
    // Port register selects on A1:A0
    localparam logic [1:0] SEL_OUT_A   = 2'h0;
    localparam logic [1:0] SEL_DIR_A   = 2'h1;
    localparam logic [1:0] SEL_OUT_B   = 2'h2;
    localparam logic [1:0] SEL_DIR_B   = 2'h3;
    // Prescale selects on A1:A0 of a timer write
    localparam logic [1:0] PRE_1       = 2'h0;
    localparam logic [1:0] PRE_8       = 2'h1;
    localparam logic [1:0] PRE_64      = 2'h2;
    localparam logic [1:0] PRE_1024    = 2'h3;
    localparam logic [9:0] DIV_1       = 10'h000;
    localparam logic [9:0] DIV_8       = 10'h007;
    localparam logic [9:0] DIV_64      = 10'h03F;
    localparam logic [9:0] DIV_1024    = 10'h3FF;
    // Flag register bit positions
    localparam int        FLAG_TIMER   = 7;
    localparam int        FLAG_EDGE    = 6;
    localparam logic [7:0] ZERO8       = 8'h00;
    localparam logic [7:0] ONES8       = 8'hFF;
    localparam logic [7:0] ONE8        = 8'h01;
    localparam logic [9:0] ZERO10      = 10'h000;
    localparam logic [9:0] ONE10       = 10'h001;

    // Bus request carrier
    typedef struct packed {
        logic              sel;
        logic              ram;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_s;
endpackage

// ===== hw/ram_io_timer_array.sv
// Memory, two ports, edge detector and interval timer behind one bus
module ram_io_timer_array (
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    input  wire logic        SYSTEM_INIT_N,
    input  wire logic        CHIP_SEL_HI,
    input  wire logic        CHIP_SEL_LO_N,
    input  wire logic        RAM_SELECT_N,
    input  wire logic        READ_NOT_WRITE,
    input  wire logic [6:0]  ADDR,
    input  wire logic [7:0]  DATA_IN,
    output logic      [7:0]  DATA_OUT,
    output logic             DATA_OE,
    output logic             IRQ_N_OUT,
    output logic             IRQ_N_OE,
    input  wire logic [7:0]  PORT_A_PINS_IN,
    output logic      [7:0]  PORT_A_PINS_OUT,
    output logic      [7:0]  PORT_A_PINS_OE,
    input  wire logic [7:0]  PORT_B_PINS_IN,
    output logic      [7:0]  PORT_B_PINS_OUT,
    output logic      [7:0]  PORT_B_PINS_OE
);
    localparam int DW = riot_pkg::DATA_W;

    // Two-stage synchronisers for pins
    logic [7:0] pa_meta;
    logic [7:0] pa_sync;
    logic [7:0] pb_meta;
    logic [7:0] pb_sync;
    logic       init_meta;
    logic       init_n_sync;
    logic       edge_pin_last;

    riot_pkg::bus_req_s req;
    logic               init;
    logic               access;
    logic               io_access;

    // Memory array
    logic [DW-1:0] ram [riot_pkg::RAM_DEPTH];

    // Register state and next values
    logic [7:0] port_a_output_value;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_output_value;
    logic [7:0] port_b_direction;
    logic       edge_rising;
    logic       edge_irq_en;
    logic       edge_flag;
    logic       timer_irq_en;
    logic       timer_flag;
    logic [7:0] timer_count;
    logic [9:0] prescale;
    logic [9:0] prescale_cnt;
    logic [7:0] next_port_a_output_value;
    logic [7:0] next_port_a_direction;
    logic [7:0] next_port_b_output_value;
    logic [7:0] next_port_b_direction;
    logic       next_edge_rising;
    logic       next_edge_irq_en;
    logic       next_edge_flag;
    logic       next_timer_irq_en;
    logic       next_timer_flag;
    logic [7:0] next_timer_count;
    logic [9:0] next_prescale;
    logic [9:0] next_prescale_cnt;
    logic [7:0] next_data_out;
    logic       next_data_oe;
    logic       next_irq_oe;
    logic [7:0] rd_mux;
    logic [7:0] port_b_view;
    logic       edge_hit;
    logic       tick;
    logic       timer_wr;
    logic       timer_rd;
    logic       flag_rd;
    logic       edge_wr;

    // Init synchroniser resets to the released level, so the bus
    // answers on the first edge after RESET falls
    // Pin and init synchronisers, first stage read only by second
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            pa_meta       <= riot_pkg::ZERO8;
            pa_sync       <= riot_pkg::ZERO8;
            pb_meta       <= riot_pkg::ZERO8;
            pb_sync       <= riot_pkg::ZERO8;
            init_meta     <= 1'b1;
            init_n_sync   <= 1'b1;
            edge_pin_last <= 1'b0;
        end else begin
            pa_meta       <= PORT_A_PINS_IN;
            pa_sync       <= pa_meta;
            pb_meta       <= PORT_B_PINS_IN;
            pb_sync       <= pb_meta;
            init_meta     <= SYSTEM_INIT_N;
            init_n_sync   <= init_meta;
            edge_pin_last <= pa_sync[7];
        end
    end

    // Bus request decode; bus is synchronous to CLOCK
    // No synchroniser here: the processor bus runs on CLOCK itself
    always_comb begin
        req.sel   = CHIP_SEL_HI && !CHIP_SEL_LO_N;
        req.ram   = !RAM_SELECT_N;
        req.rd    = READ_NOT_WRITE;
        req.addr  = ADDR;
        req.wdata = DATA_IN;
    end
    assign init      = RESET || !init_n_sync;
    assign access    = req.sel && !init;
    assign io_access = access && !req.ram;

    // Access classification from A4, A2, A0
    // A2 low is a port register; those are decoded with the writes
    always_comb begin
        timer_wr = 1'b0;
        timer_rd = 1'b0;
        flag_rd  = 1'b0;
        edge_wr  = 1'b0;
        if (!io_access || !req.addr[riot_pkg::A_BIT2]) begin
            timer_wr = 1'b0;
        end else if (!req.rd && req.addr[riot_pkg::A_BIT4]) begin
            timer_wr = 1'b1;
        end else if (!req.rd) begin
            edge_wr = 1'b1;
        end else if (!req.addr[riot_pkg::A_BIT0]) begin
            timer_rd = 1'b1;
        end else begin
            flag_rd = 1'b1;
        end
    end

    // Edge detect: flag sets regardless of direction and enable
    // Pin to flag takes three clocks: two sync stages and a compare
    // active edge
    assign edge_hit = edge_rising ? (pa_sync[7] && !edge_pin_last)
                                  : (!pa_sync[7] && edge_pin_last);
    // Prescaler tick; after timeout the count runs every clock
    // Prescale phase restarts on a timer write, and after timeout on the timer access that clears the flag
    assign tick = (prescale_cnt == riot_pkg::ZERO10) || timer_flag;

    // port B read view: register on driven lines, pin on inputs
    for (genvar b = 0; b < DW; b++) begin : g_view_b
        assign port_b_view[b] = port_b_direction[b] ? port_b_output_value[b]
                                                    : pb_sync[b];
    end

    // Next state for registers, edge logic and timer
    always_comb begin
        next_port_a_output_value = port_a_output_value;
        next_port_a_direction    = port_a_direction;
        next_port_b_output_value = port_b_output_value;
        next_port_b_direction    = port_b_direction;
        next_edge_rising         = edge_rising;
        next_edge_irq_en         = edge_irq_en;
        next_edge_flag           = edge_flag;
        next_timer_irq_en        = timer_irq_en;
        next_timer_flag          = timer_flag;
        next_timer_count         = timer_count;
        next_prescale            = prescale;
        next_prescale_cnt        = prescale_cnt;
        // A read clear is applied first so a coinciding edge wins
        // clear after read
        if (flag_rd) begin
            next_edge_flag = 1'b0;
        end
        if (edge_hit) begin
            next_edge_flag = 1'b1;
        end
        // The data byte of this write is discarded
        // polarity and enable from address
        if (edge_wr) begin
            next_edge_rising = req.addr[riot_pkg::A_BIT0];
            next_edge_irq_en = req.addr[riot_pkg::A_BIT1];
        end
        // port register writes, stored regardless of direction
        if (io_access && !req.rd && !req.addr[riot_pkg::A_BIT2]) begin
            if (req.addr[1:0] == riot_pkg::SEL_OUT_A) begin
                next_port_a_output_value = req.wdata;
            end else if (req.addr[1:0] == riot_pkg::SEL_DIR_A) begin
                next_port_a_direction = req.wdata;
            end else if (req.addr[1:0] == riot_pkg::SEL_OUT_B) begin
                next_port_b_output_value = req.wdata;
            end else begin
                next_port_b_direction = req.wdata;
            end
        end
        // countdown, all ones after zero
        // Past timeout the count reads clocks since, two's complement
        if (tick) begin
            next_prescale_cnt = prescale;
            // stop at zero, 255 clocks past timeout
            if (!(timer_flag && timer_count == riot_pkg::ZERO8)) begin
                next_timer_count = timer_count - riot_pkg::ONE8;
            end
            if (timer_count == riot_pkg::ZERO8 && !timer_flag) begin
                next_timer_flag = 1'b1;
            end
        end else begin
            next_prescale_cnt = prescale_cnt - riot_pkg::ONE10;
        end
        // enable from A3 on any timer access
        if (timer_wr || timer_rd) begin
            next_timer_irq_en = req.addr[riot_pkg::A_BIT3];
        end
        // Tested on the old flag so a setting tick is never lost
        // clear unless flag is being set this clock
        if ((timer_wr || timer_rd) && timer_flag) begin
            next_timer_flag = 1'b0;
        end
        if (timer_wr) begin
            next_timer_count = req.wdata;
            case (req.addr[1:0])
                riot_pkg::PRE_1:   next_prescale = riot_pkg::DIV_1;
                riot_pkg::PRE_8:   next_prescale = riot_pkg::DIV_8;
                riot_pkg::PRE_64:  next_prescale = riot_pkg::DIV_64;
                default:           next_prescale = riot_pkg::DIV_1024;
            endcase
            next_prescale_cnt = next_prescale;
        end
    end

    // Read data mux
    // RAM select has priority; I/O decode only with it high
    always_comb begin
        rd_mux = riot_pkg::ZERO8;
        if (req.ram) begin
            rd_mux = ram[req.addr];
        end else if (flag_rd) begin
            rd_mux[riot_pkg::FLAG_TIMER] = timer_flag;
            rd_mux[riot_pkg::FLAG_EDGE]  = edge_flag;
        end else if (timer_rd) begin
            rd_mux = timer_count;
        end else if (req.addr[1:0] == riot_pkg::SEL_OUT_A) begin
            rd_mux = pa_sync;
        end else if (req.addr[1:0] == riot_pkg::SEL_DIR_A) begin
            rd_mux = port_a_direction;
        end else if (req.addr[1:0] == riot_pkg::SEL_OUT_B) begin
            rd_mux = port_b_view;
        end else begin
            rd_mux = port_b_direction;
        end
    end

    // Data bus and interrupt output next values
    // Zero when idle so no stale byte lingers on DATA_OUT
    always_comb begin
        // drive only on a selected read
        next_data_oe  = access && req.rd;
        next_data_out = next_data_oe ? rd_mux : riot_pkg::ZERO8;
        // pull low while an enabled flag is set
        next_irq_oe   = !init && ((timer_flag && timer_irq_en)
                                  || (edge_flag && edge_irq_en));
    end

    // Init leaves the memory contents untouched
    // memory write, one byte per selected access
    always_ff @(posedge CLOCK) begin
        if (access && req.ram && !req.rd) begin
            ram[req.addr] <= req.wdata;
        end
    end

    // State registers; init clears ports and interrupt settings
    always_ff @(posedge CLOCK) begin
        if (init) begin
            // clear ports, falling edge, interrupts off
            port_a_output_value <= riot_pkg::ZERO8;
            port_a_direction    <= riot_pkg::ZERO8;
            port_b_output_value <= riot_pkg::ZERO8;
            port_b_direction    <= riot_pkg::ZERO8;
            edge_rising         <= 1'b0;
            edge_irq_en         <= 1'b0;
            timer_irq_en        <= 1'b0;
            edge_flag           <= 1'b0;
            timer_flag          <= 1'b0;
            timer_count         <= riot_pkg::ZERO8;
            prescale            <= riot_pkg::DIV_1024;
            prescale_cnt        <= riot_pkg::DIV_1024;
            DATA_OUT            <= riot_pkg::ZERO8;
            DATA_OE             <= 1'b0;
            IRQ_N_OE            <= 1'b0;
            PORT_A_PINS_OUT     <= riot_pkg::ZERO8;
            PORT_A_PINS_OE      <= riot_pkg::ZERO8;
            PORT_B_PINS_OUT     <= riot_pkg::ZERO8;
            PORT_B_PINS_OE      <= riot_pkg::ZERO8;
        end else begin
            port_a_output_value <= next_port_a_output_value;
            port_a_direction    <= next_port_a_direction;
            port_b_output_value <= next_port_b_output_value;
            port_b_direction    <= next_port_b_direction;
            edge_rising         <= next_edge_rising;
            edge_irq_en         <= next_edge_irq_en;
            timer_irq_en        <= next_timer_irq_en;
            edge_flag           <= next_edge_flag;
            timer_flag          <= next_timer_flag;
            timer_count         <= next_timer_count;
            prescale            <= next_prescale;
            prescale_cnt        <= next_prescale_cnt;
            DATA_OUT            <= next_data_out;
            DATA_OE             <= next_data_oe;
            IRQ_N_OE            <= next_irq_oe;
            // Next values so pins move on the same edge as the write
            // output lines follow their direction bits
            PORT_A_PINS_OUT     <= next_port_a_output_value;
            PORT_A_PINS_OE      <= next_port_a_direction;
            PORT_B_PINS_OUT     <= next_port_b_output_value;
            PORT_B_PINS_OE      <= next_port_b_direction;
        end
    end

    // Open-drain request: the driven level is always low
    // Only the enable moves; the line is never driven high
    always_ff @(posedge CLOCK) begin
        IRQ_N_OUT <= 1'b0;
    end
endmodule

// ===== testbench/ram_io_timer_array_chk.sv
// Checker: bus, port and reset relations at the array's pins
module ram_io_timer_array_chk (
    input wire logic       CLOCK,
    input wire logic       RESET,
    input wire logic       SYSTEM_INIT_N,
    input wire logic       CHIP_SEL_HI,
    input wire logic       CHIP_SEL_LO_N,
    input wire logic       RAM_SELECT_N,
    input wire logic       READ_NOT_WRITE,
    input wire logic [6:0] ADDR,
    input wire logic [7:0] DATA_IN,
    input wire logic [7:0] DATA_OUT,
    input wire logic       DATA_OE,
    input wire logic       IRQ_N_OE,
    input wire logic [7:0] PORT_A_PINS_OE,
    input wire logic [7:0] PORT_A_PINS_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // Decoded access kinds
    logic sel;
    logic io_wr;
    assign sel = CHIP_SEL_HI && !CHIP_SEL_LO_N;
    assign io_wr = sel && !READ_NOT_WRITE && RAM_SELECT_N && !ADDR[2];
    sequence s_ram_wr;
        sel && !READ_NOT_WRITE && !RAM_SELECT_N;
    endsequence
    sequence s_ram_rd;
        sel && READ_NOT_WRITE && !RAM_SELECT_N && ADDR == $past(ADDR, 2);
    endsequence
    sequence s_init_end;
        !SYSTEM_INIT_N ##1 SYSTEM_INIT_N;
    endsequence
    property p_ram;
        s_ram_wr ##2 s_ram_rd |=> DATA_OUT == $past(DATA_IN, 3);
    endproperty
    a_ram: assert property (p_ram) else $error("memory byte lost");
    property p_oe;
        DATA_OE |-> $past(sel && READ_NOT_WRITE);
    endproperty
    a_oe: assert property (p_oe) else $error("bus driven idle");
    property p_rd;
        sel && READ_NOT_WRITE |=> DATA_OE;
    endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_init;
        s_init_end |-> ##2 (PORT_A_PINS_OE == 8'h00
            && PORT_A_PINS_OUT == 8'h00 && !DATA_OE);
    endproperty
    a_init: assert property (p_init) else $error("init left state");
    property p_dir_a;
        io_wr && ADDR[1:0] == riot_pkg::SEL_DIR_A
            |=> PORT_A_PINS_OE == $past(DATA_IN);
    endproperty
    a_dir_a: assert property (p_dir_a) else $error("direction lost");
    property p_out_a;
        io_wr && ADDR[1:0] == riot_pkg::SEL_OUT_A
            |=> PORT_A_PINS_OUT == $past(DATA_IN);
    endproperty
    a_out_a: assert property (p_out_a) else $error("output reg lost");
    property p_flag;
        sel && READ_NOT_WRITE && RAM_SELECT_N && ADDR[2] && ADDR[0]
            |=> DATA_OUT[5:0] == 6'h00;
    endproperty
    a_flag: assert property (p_flag) else $error("flag bits set");
    property p_reset;
        disable iff (1'h0) RESET |=> !IRQ_N_OE && !DATA_OE;
    endproperty
    a_reset: assert property (p_reset) else $error("reset ignored");
endmodule
bind ram_io_timer_array ram_io_timer_array_chk chk (
    .CLOCK(CLOCK), .RESET(RESET), .SYSTEM_INIT_N(SYSTEM_INIT_N),
    .CHIP_SEL_HI(CHIP_SEL_HI), .CHIP_SEL_LO_N(CHIP_SEL_LO_N),
    .RAM_SELECT_N(RAM_SELECT_N), .READ_NOT_WRITE(READ_NOT_WRITE),
    .ADDR(ADDR), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
    .DATA_OE(DATA_OE), .IRQ_N_OE(IRQ_N_OE),
    .PORT_A_PINS_OE(PORT_A_PINS_OE), .PORT_A_PINS_OUT(PORT_A_PINS_OUT)
);

// ===== testbench/cpu_bus_model.sv
// Processor bus model: one access per call, init pulse on request
module cpu_bus_model (
    input  wire logic       clock,
    input  wire logic [7:0] data_out,
    output logic            chip_sel_hi,
    output logic            chip_sel_lo_n,
    output logic            ram_select_n,
    output logic            read_not_write,
    output logic [6:0]      addr,
    output logic [7:0]      data_in,
    output logic            system_init_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle, deselected bus at time zero
    initial begin
        {chip_sel_hi, chip_sel_lo_n, ram_select_n} = 3'h3;
        read_not_write = 1'h1;
        addr = 7'h00;
        data_in = 8'h00;
        system_init_n = 1'h1;
    end
    task automatic access(input logic ram, input logic rd,
                          input logic [6:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge clock);
        {chip_sel_hi, chip_sel_lo_n, ram_select_n} = {2'h2, !ram};
        read_not_write = rd;
        addr = a;
        data_in = d;
        @(negedge clock);
        q = data_out;
        {chip_sel_hi, chip_sel_lo_n} = 2'h1;
        data_in = ~d; // Released bus must not show a stale byte
    endtask
    task automatic init_pulse;
        @(negedge clock);
        system_init_n = 1'h0;
        repeat (3) @(negedge clock);
        system_init_n = 1'h1;
    endtask
endmodule

// ===== testbench/test_ram_io_timer_array.sv
// Testbench: ports, memory, edge detector, timer and init of the array
module test_ram_io_timer_array;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock, reset, sh, sl, rs, rw, init_n, doe, irq_o, irq;
    logic [6:0] addr;
    logic [7:0] din, dout, ao, aoe, bo, boe, ext_a, ext_b, pa, pb, q;
    int         failures, checks;
    // Pin levels: driven bits from the array, others from outside
    assign pa = (aoe & ao) | (~aoe & ext_a);
    assign pb = (boe & bo) | (~boe & ext_b);
    ram_io_timer_array uut (.CLOCK(clock), .RESET(reset),
        .SYSTEM_INIT_N(init_n), .CHIP_SEL_HI(sh), .CHIP_SEL_LO_N(sl),
        .RAM_SELECT_N(rs), .READ_NOT_WRITE(rw), .ADDR(addr),
        .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .IRQ_N_OUT(irq_o),
        .IRQ_N_OE(irq), .PORT_A_PINS_IN(pa), .PORT_A_PINS_OUT(ao),
        .PORT_A_PINS_OE(aoe), .PORT_B_PINS_IN(pb), .PORT_B_PINS_OUT(bo),
        .PORT_B_PINS_OE(boe));
    cpu_bus_model cpu (.clock(clock), .data_out(dout), .chip_sel_hi(sh),
        .chip_sel_lo_n(sl), .ram_select_n(rs), .read_not_write(rw),
        .addr(addr), .data_in(din), .system_init_n(init_n));
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic ram, input logic [6:0] a,
                      input logic [7:0] d);
        cpu.access(ram, 1'h0, a, d, q);
    endtask
    task automatic rd(input logic ram, input logic [6:0] a,
                      input logic [7:0] exp);
        cpu.access(ram, 1'h1, a, 8'h00, q);
        check8(q, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic test_ports;
        wr(1'h0, 7'h00, 8'hA5);
        check8(ao | aoe, 8'hA5);
        check8(pa, 8'h3C);
        wr(1'h0, 7'h01, 8'h0F);
        wr(1'h0, 7'h02, 8'hC3);
        wr(1'h0, 7'h03, 8'hF0);
        check8(pb & boe, 8'hC0);
        check8(pa & aoe, 8'h05);
        idle(3);
        rd(1'h0, 7'h00, 8'h35);
        rd(1'h0, 7'h01, 8'h0F);
        rd(1'h0, 7'h02, 8'hCA);
    endtask
    task automatic test_ram;
        logic [6:0] a [4] = '{7'h00, 7'h7F, 7'h2A, 7'h55};
        foreach (a[i]) begin
            wr(1'h1, a[i], {a[i], 1'h1});
            rd(1'h1, a[i], {a[i], 1'h1});
        end
        foreach (a[i]) rd(1'h1, a[i], {a[i], 1'h1});
    endtask
    task automatic test_edge;
        rd(1'h0, 7'h05, 8'h00);
        wr(1'h0, 7'h06, 8'hFF); // Enable, falling; byte is ignored
        ext_a[7] = 1'h1;
        idle(5);
        rd(1'h0, 7'h05, 8'h00);
        ext_a[7] = 1'h0;
        idle(5);
        check8({7'h00, irq}, 8'h01);
        check8({7'h00, irq_o}, 8'h00);
        rd(1'h0, 7'h05, 8'h40);
        idle(2);
        check8({7'h00, irq}, 8'h00);
        rd(1'h0, 7'h05, 8'h00);
        wr(1'h0, 7'h05, 8'h00);
        wr(1'h0, 7'h01, 8'h8F); // Bit 7 driven high by the array
        idle(5);
        check8({7'h00, irq}, 8'h00);
        rd(1'h0, 7'h05, 8'h40);
    endtask
    task automatic test_timer;
        int n;
        int dv [4] = '{32'h1, 32'h8, 32'h40, 32'h400};
        wr(1'h0, 7'h1F, 8'h03);
        rd(1'h0, 7'h0C, 8'h03);
        idle(1100);
        rd(1'h0, 7'h0C, 8'h02);
        for (int p = 0; p < 4; p++) begin
            wr(1'h0, 7'h1C | 7'(p), 8'h02);
            n = 0;
            while (irq !== 1'h1 && n < 5000) begin
                idle(1);
                n++;
            end
            check8({7'h00, n >= 2 * dv[p] && n <= 3 * dv[p] + 6}, 8'h01);
            rd(1'h0, 7'h05, 8'h80);
            cpu.access(1'h0, 1'h1, 7'h04, 8'h00, q);
            check8(q & 8'hF0, 8'hF0);
            idle(2);
            check8({7'h00, irq}, 8'h00);
            rd(1'h0, 7'h05, 8'h00);
        end
        // Count 1, divide 1: a timer read lands on the setting clock
        wr(1'h0, 7'h14, 8'h01);
        rd(1'h0, 7'h04, 8'h00);
        rd(1'h0, 7'h05, 8'h80);
        idle(300);
        rd(1'h0, 7'h04, 8'h00);
        wr(1'h0, 7'h17, 8'hFF);
        rd(1'h0, 7'h05, 8'h00);
    endtask
    task automatic test_init;
        cpu.init_pulse();
        idle(3);
        check8(aoe | ao | boe | bo, 8'h00);
        check8({7'h00, doe}, 8'h00);
    endtask
    task automatic complete_run;
        if (failures == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Free-running clock
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    // Reset, then each scenario in turn
    initial begin
        {reset, ext_a, ext_b} = {1'h1, 8'h3C, 8'h5A};
        failures = 0;
        checks = 0;
        repeat (16) @(negedge clock);
        reset = 1'h0;
        check8({7'h00, irq}, 8'h00);
        test_ports();
        test_ram();
        test_edge();
        test_timer();
        test_init();
        complete_run();
    end
    // Watchdog: whole run needs well under this many clocks
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        complete_run();
    end
endmodule
